/* File: hdl/crx_rx_flags.sv */
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module crx_rx_flags
  import crx_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] filt_mask_sel,
  input wire logic [15:0] filt_eid_value,
  input wire logic [15:0] frame_eid,
  output logic filt_eid_match,
  input wire logic store_valid,
  input wire logic [4:0] store_index,
  output logic [31:0] buffer_full_flags,
  output logic [31:0] buffer_overflow_flags,
  output logic irq
);
  logic [15:0] mask_r [NUM_MASKS];
  logic [31:0] full_r;
  logic [31:0] ovf_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [31:0] prdata_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [15:0] sel_mask;
  logic [31:0] store_hit;
  logic [31:0] sw_clr;
  logic store_ovf;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Single-cycle access phase; unmapped addresses answer with pslverr
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  always_comb begin
    unique case (paddr)
      ADDR_MASK0, ADDR_MASK1, ADDR_MASK2, ADDR_FULL_LOW, ADDR_FULL_HIGH,
      ADDR_OVF_LOW, ADDR_OVF_HIGH, ADDR_IRQ_STAT, ADDR_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // ------------------------------------------------------------
  // Acceptance mask, extended id half
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_MASKS; i++) begin
        mask_r[i] <= MASK_RESET;
      end
    end else if (wr_en) begin
      if (paddr == ADDR_MASK0) mask_r[0] <= pwdata[15:0];
      if (paddr == ADDR_MASK1) mask_r[1] <= pwdata[15:0];
      if (paddr == ADDR_MASK2) mask_r[2] <= pwdata[15:0];
    end
  end

  // Select code 3 is reserved; it behaves as all don't care
  assign sel_mask = (filt_mask_sel < 2'd3) ? mask_r[filt_mask_sel] : 16'h0000;
  // Only bits with mask one are compared; zeros never block a match
  assign filt_eid_match = ((frame_eid ^ filt_eid_value) & sel_mask) == 16'h0000;

  // ------------------------------------------------------------
  // Full and overflow flags
  // ------------------------------------------------------------
  assign store_hit = store_valid ? (32'h0000_0001 << store_index) : 32'h0000_0000;
  always_comb begin
    sw_clr = 32'h0000_0000;
    if (wr_en && paddr == ADDR_FULL_LOW) sw_clr[15:0] = ~pwdata[15:0];
    if (wr_en && paddr == ADDR_FULL_HIGH) sw_clr[31:16] = ~pwdata[15:0];
  end

  // Set wins over a clear in the same cycle so no store is lost
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      full_r <= {FULL_RESET, FULL_RESET};
    end else begin
      full_r <= (full_r & ~sw_clr) | store_hit;
    end
  end

  assign store_ovf = |(store_hit & full_r);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_r <= {OVF_RESET, OVF_RESET};
    end else begin
      logic [31:0] oclr;
      oclr = 32'h0000_0000;
      if (wr_en && paddr == ADDR_OVF_LOW) oclr[15:0] = ~pwdata[15:0];
      if (wr_en && paddr == ADDR_OVF_HIGH) oclr[31:16] = ~pwdata[15:0];
      ovf_r <= (ovf_r & ~oclr) | (store_hit & full_r);
    end
  end

  assign buffer_full_flags = full_r;
  assign buffer_overflow_flags = ovf_r;

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  // Status clears on read; a new event in the read cycle survives
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= IRQ_RESET;
    end else begin
      logic [1:0] ev;
      ev = 2'b00;
      ev[IRQ_BIT_STORE] = store_valid;
      ev[IRQ_BIT_OVF] = store_ovf;
      if (rd_en && paddr == ADDR_IRQ_STAT) irq_stat_r <= ev;
      else irq_stat_r <= irq_stat_r | ev;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_r <= IRQ_RESET;
    end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
      irq_mask_r <= pwdata[1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    unique case (paddr)
      ADDR_MASK0: prdata_r = {16'h0000, mask_r[0]};
      ADDR_MASK1: prdata_r = {16'h0000, mask_r[1]};
      ADDR_MASK2: prdata_r = {16'h0000, mask_r[2]};
      ADDR_FULL_LOW: prdata_r = {16'h0000, full_r[15:0]};
      ADDR_FULL_HIGH: prdata_r = {16'h0000, full_r[31:16]};
      ADDR_OVF_LOW: prdata_r = {16'h0000, ovf_r[15:0]};
      ADDR_OVF_HIGH: prdata_r = {16'h0000, ovf_r[31:16]};
      ADDR_IRQ_STAT: prdata_r = {30'h0, irq_stat_r};
      ADDR_IRQ_MASK: prdata_r = {30'h0, irq_mask_r};
      default: prdata_r = 32'h0000_0000;
    endcase
  end
  assign prdata = rd_en ? prdata_r : 32'h0000_0000;
endmodule : crx_rx_flags

/* File: shared/crx_pkg.sv */
package crx_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_MASK0 = 8'h00;
  localparam logic [7:0] ADDR_MASK1 = 8'h04;
  localparam logic [7:0] ADDR_MASK2 = 8'h08;
  localparam logic [7:0] ADDR_FULL_LOW = 8'h0C;
  localparam logic [7:0] ADDR_FULL_HIGH = 8'h10;
  localparam logic [7:0] ADDR_OVF_LOW = 8'h14;
  localparam logic [7:0] ADDR_OVF_HIGH = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  // ------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] FULL_RESET = 16'h0000;
  localparam logic [15:0] OVF_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int IRQ_BIT_STORE = 0;
  localparam int IRQ_BIT_OVF = 1;
  localparam int NUM_MASKS = 3;
  localparam int NUM_BUFS = 32;
endpackage : crx_pkg

/* File: test/crx_rx_flags_assertions.sv */
`timescale 1ns/1ps
module crx_rx_flags_chk
  import crx_pkg::*;
(
  input wire logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, store_valid, filt_eid_match,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, buffer_full_flags, buffer_overflow_flags,
  input wire logic [4:0] store_index,
  input wire logic [1:0] filt_mask_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic acc, wlo, whi;
  assign acc = psel && penable;
  assign wlo = acc && pwrite && paddr == ADDR_FULL_LOW;
  assign whi = acc && pwrite && paddr == ADDR_FULL_HIGH;
  store_sets_a: assert property (store_valid |=> buffer_full_flags[$past(store_index)])
    else $error("full flag not set");
  no_hw_clear_a: assert property (!wlo && !whi |=>
    (buffer_full_flags & $past(buffer_full_flags)) == $past(buffer_full_flags)) else $error("flag lost");
  low_clear_a: assert property (wlo && !store_valid |=>
    buffer_full_flags == ($past(buffer_full_flags) & {16'hFFFF, $past(pwdata[15:0])})) else $error("low write");
  high_clear_a: assert property (whi && !store_valid |=>
    buffer_full_flags == ($past(buffer_full_flags) & {$past(pwdata[15:0]), 16'hFFFF})) else $error("high write");
  ovf_sets_a: assert property (store_valid && buffer_full_flags[store_index] |=>
    buffer_overflow_flags[$past(store_index)]) else $error("overflow not set");
  mask_none_a: assert property (filt_mask_sel == 2'h3 |-> filt_eid_match)
    else $error("no mask yet no match");
  zero_wait_a: assert property (acc |-> pready) else $error("wait state");
  unmapped_err_a: assert property (acc && paddr > ADDR_IRQ_MASK |-> pslverr) else $error("no slave error");
  cover property (store_valid && buffer_full_flags[store_index]);
  cover property (wlo && !store_valid);
  cover property (filt_mask_sel == 2'h0 && filt_eid_match);
endmodule : crx_rx_flags_chk
bind crx_rx_flags crx_rx_flags_chk crx_rx_flags_chk_inst (.mclk, .reset_n, .psel, .penable, .pwrite, .pready,
  .pslverr, .store_valid, .filt_eid_match, .paddr, .pwdata, .buffer_full_flags, .buffer_overflow_flags,
  .store_index, .filt_mask_sel);

/* File: test/crx_can_node.sv */
`timescale 1ns/1ps
module crx_can_node (
  input wire logic mclk, reset_n, send,
  input wire logic [4:0] idx,
  output logic store_valid,
  output logic [4:0] store_index
);
  // Idle index toggles so a stale value is never trusted
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      store_valid <= 1'b0;
      store_index <= 5'h00;
    end else begin
      store_valid <= send;
      store_index <= send ? idx : ~store_index;
    end
  end
endmodule : crx_can_node

/* File: test/crx_rx_flags_test.sv */
`timescale 1ns/1ps
module crx_rx_flags_test
  import crx_pkg::*;
;
  logic mclk = 0, reset_n, psel = 0, penable = 0, pwrite = 0, send = 0, pready, pslverr, er, store_valid, match, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, fl, ov;
  logic [1:0] sel = 2'h0;
  logic [15:0] fval = 16'h0, feid = 16'h0;
  logic [4:0] idx = 5'h00, store_index;
  logic [34:0] rows [6] = '{{2'h0, 16'hAB34, 16'h0034, 1'b1}, {2'h0, 16'hAB34, 16'hAB35, 1'b0},
    {2'h1, 16'hAB34, 16'hAB00, 1'b1}, {2'h1, 16'hAB34, 16'hAC34, 1'b0}, {2'h2, 16'h0000, 16'hFFFF, 1'b1},
    {2'h3, 16'h1234, 16'h4321, 1'b1}};
  int fails = 0, compares = 0;
  crx_rx_flags crx_rx_flags_inst (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .filt_mask_sel(sel), .filt_eid_value(fval), .frame_eid(feid), .filt_eid_match(match), .store_valid,
    .store_index, .buffer_full_flags(fl), .buffer_overflow_flags(ov), .irq);
  crx_can_node crx_can_node_inst (.mclk, .reset_n, .send, .idx, .store_valid, .store_index);
  always #50 mclk = ~mclk;
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Read data and error taken at the very edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the flags settle before any compare
    @(negedge mclk);
  endtask : apb
  task automatic store(input logic [4:0] i);
    @(posedge mclk);
    send <= 1'b1;
    idx <= i;
    @(posedge mclk);
    send <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
  endtask : store
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    #2000000;
    fails++;
    final_report;
  end
  initial begin
    reset_n = 1'b0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    apb(0, ADDR_FULL_LOW, 0);
    chk(rd, 32'h0);
    apb(0, ADDR_FULL_HIGH, 0);
    chk(rd, 32'h0);
    apb(1, ADDR_MASK0, 32'h00FF);
    apb(1, ADDR_MASK1, 32'hFF00);
    apb(1, ADDR_MASK2, 32'h0);
    apb(0, ADDR_MASK1, 0);
    chk(rd, 32'hFF00);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      {sel, fval, feid} <= rows[i][34:1];
      @(negedge mclk);
      chk(match, rows[i][0]);
    end
    store(3);
    store(20);
    chk(fl, 32'h0010_0008);
    apb(0, ADDR_FULL_LOW, 0);
    chk(rd, 32'h8);
    apb(0, ADDR_FULL_HIGH, 0);
    chk(rd, 32'h10);
    store(3);
    chk(ov, 32'h8);
    apb(1, ADDR_FULL_LOW, 32'hFFF7);
    chk(fl, 32'h0010_0000);
    apb(1, ADDR_FULL_HIGH, 32'hFFFF);
    chk(fl, 32'h0010_0000);
    apb(1, ADDR_FULL_HIGH, 0);
    chk(fl, 32'h0);
    apb(1, ADDR_IRQ_MASK, 0);
    chk(irq, 0);
    apb(1, ADDR_IRQ_MASK, 3);
    chk(irq, 1);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h3);
    chk(irq, 0);
    // Reset in mid-run clears every flag and register
    store(7);
    @(posedge mclk);
    reset_n <= 1'b0;
    @(negedge mclk);
    chk(fl, 32'h0);
    chk(ov, 32'h0);
    chk(irq, 0);
    @(posedge mclk);
    reset_n <= 1'b1;
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h0);
    apb(0, ADDR_MASK1, 0);
    chk(rd, 32'h0);
    apb(0, 8'h40, 0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    final_report;
  end
endmodule : crx_rx_flags_test
